// file: hw/tws_shift_unit.sv
`timescale 1ns/1ps
module tws_shift_unit
   import tws_pkg::*;
#(
   parameter int unsigned ADDR_W = 8
)(
   // Clock and reset
   input  wire logic              CLK,
   input  wire logic              NRST,
   // AXI4-Lite write
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic              S_AXI_AWVALID,
   output logic                   S_AXI_AWREADY,
   input  wire logic [31:0]       S_AXI_WDATA,
   input  wire logic [3:0]        S_AXI_WSTRB,
   input  wire logic              S_AXI_WVALID,
   output logic                   S_AXI_WREADY,
   output logic [1:0]             S_AXI_BRESP,
   output logic                   S_AXI_BVALID,
   input  wire logic              S_AXI_BREADY,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic              S_AXI_ARVALID,
   output logic                   S_AXI_ARREADY,
   output logic [31:0]            S_AXI_RDATA,
   output logic [1:0]             S_AXI_RRESP,
   output logic                   S_AXI_RVALID,
   input  wire logic              S_AXI_RREADY,
   // Timer compare match, same clock
   input  wire logic              TIMER_MATCH,
   // Data pin (serial input / SDA)
   input  wire logic              SDA_I,
   output logic                   SDA_O,
   output logic                   SDA_OE,
   // Clock pin (shift clock / SCL)
   input  wire logic              SCL_I,
   output logic                   SCL_O,
   output logic                   SCL_OE,
   // Three-wire data output
   output logic                   DO_O,
   output logic                   DO_OE,
   // Interrupt requests
   output logic                   START_IRQ,
   output logic                   OVF_IRQ
);

   function automatic logic reg_sel(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
      reg_sel = (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]) && (addr[1:0] == 2'h0);
   endfunction : reg_sel

   logic              rst_s1_q;
   logic              rst_n;
   logic [2:0]        pin_s_q   [2];
   logic              pin_lvl_q [2];
   logic              pin_prv_q [2];
   logic [1:0]        pin_in;
   logic              awready_q;
   logic              wready_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              arready_q;
   logic              rvalid_q;
   logic [1:0]        rresp_q;
   logic [7:0]        rdata_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [7:0]        wdata_q;
   logic              wstrb0_q;
   tws_ctrl_type      ctrl_q;
   tws_port_type      port_q;
   tws_port_type      port_d;
   logic [7:0]        data_q;
   logic [7:0]        data_d;
   logic [7:0]        buf_q;
   logic [3:0]        cnt_q;
   logic [3:0]        cnt_d;
   logic              start_q;
   logic              start_d;
   logic              start_hold_q;
   logic              start_hold_d;
   logic              ovf_q;
   logic              stop_q;
   logic              latch_q;
   logic              sda_o_q;
   logic              sda_oe_q;
   logic              scl_o_q;
   logic              scl_oe_q;
   logic              do_o_q;
   logic              do_oe_q;
   logic              start_irq_q;
   logic              ovf_irq_q;

   // Reset release
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   // Pin synchronisers; index 0 data pin, 1 clock pin. Idle bus level is high.
   assign pin_in = {SCL_I, SDA_I};
   for (genvar g = 0; g < 2; g++)
   begin : g_sync
      always_ff @(posedge CLK or negedge rst_n)
      begin
         if (!rst_n)
         begin
            pin_s_q[g]   <= 3'h7;
            pin_lvl_q[g] <= 1'b1;
            pin_prv_q[g] <= 1'b1;
         end
         else
         begin
            pin_s_q[g]   <= {pin_s_q[g][1:0], pin_in[g]};
            pin_lvl_q[g] <= (pin_s_q[g][1] == pin_s_q[g][2]) ? pin_s_q[g][2] : pin_lvl_q[g];
            pin_prv_q[g] <= pin_lvl_q[g];
         end
      end
   end

   // Line events
   wire sda_lvl  = pin_lvl_q[0];
   wire scl_lvl  = pin_lvl_q[1];
   wire sda_rise = sda_lvl & ~pin_prv_q[0];
   wire sda_fall = ~sda_lvl & pin_prv_q[0];
   wire scl_rise = scl_lvl & ~pin_prv_q[1];
   wire scl_fall = ~scl_lvl & pin_prv_q[1];
   wire scl_edge = scl_rise | scl_fall;
   wire scl_high = scl_lvl & pin_prv_q[1];
   wire start_det = sda_fall & scl_high;
   wire stop_det  = sda_rise & scl_high;

   // Bus slave
   wire wr_fire   = ~awready_q & ~wready_q & ~bvalid_q;
   wire wr_en     = wr_fire & wstrb0_q;
   wire wr_ctrl   = wr_en & reg_sel(awaddr_q, IDX_CTRL);
   wire wr_status = wr_en & reg_sel(awaddr_q, IDX_STATUS);
   wire wr_data   = wr_en & reg_sel(awaddr_q, IDX_DATA);
   wire wr_port   = wr_en & reg_sel(awaddr_q, IDX_PORT);
   wire wr_hit    = reg_sel(awaddr_q, IDX_CTRL) | reg_sel(awaddr_q, IDX_STATUS) |
                    reg_sel(awaddr_q, IDX_DATA) | reg_sel(awaddr_q, IDX_BUFFER) |
                    reg_sel(awaddr_q, IDX_PORT);
   wire rd_fire   = S_AXI_ARVALID & arready_q;
   wire rs_ctrl   = reg_sel(S_AXI_ARADDR, IDX_CTRL);
   wire rs_status = reg_sel(S_AXI_ARADDR, IDX_STATUS);
   wire rs_data   = reg_sel(S_AXI_ARADDR, IDX_DATA);
   wire rs_buffer = reg_sel(S_AXI_ARADDR, IDX_BUFFER);
   wire rs_port   = reg_sel(S_AXI_ARADDR, IDX_PORT);
   wire rd_hit    = rs_ctrl | rs_status | rs_data | rs_buffer | rs_port;

   // Mode decode
   wire two_wire   = ctrl_q.wire_mode_select[1];
   wire three_wire = ctrl_q.wire_mode_select == WM_THREE;
   wire ext_clk    = ctrl_q.clock_source_select[1];
   wire sw_clk     = wr_ctrl & wdata_q[CT_SWCLK];
   wire sw_toggle  = wr_ctrl & wdata_q[CT_TOGGLE];
   wire start_clr  = wr_status & wdata_q[ST_START];
   wire ovf_clr    = wr_status & wdata_q[ST_OVF];
   wire stop_clr   = wr_status & wdata_q[ST_STOP];
   wire collision  = two_wire & (data_q[7] != sda_lvl);

   // Shift and count clocks; pins are used whatever the wire mode
   wire shift_ev = (ctrl_q.clock_source_select == CS_SOFT)  ? sw_clk :
                   (ctrl_q.clock_source_select == CS_TIMER) ? TIMER_MATCH :
                   (ctrl_q.clock_source_select == CS_RISE)  ? scl_rise :
                   scl_fall;
   // Software toggle counts only when the strobe pair is written together
   wire cnt_ev   = ext_clk ? (sw_clk ? sw_toggle : scl_edge) : shift_ev;
   wire ovf_ev   = cnt_ev & ~wr_status & (cnt_q == CNT_MAX);
   wire start_ev = two_wire ? start_det : scl_edge;
   wire stop_ev  = two_wire & stop_det;

   assign data_d = wr_data  ? wdata_q :
                   shift_ev ? {data_q[6:0], sda_lvl} : data_q;
   // Counter write wins over counting; software acks by loading 14
   assign cnt_d  = wr_status ? wdata_q[3:0] :
                   cnt_ev ? cnt_q + 4'h1 : cnt_q;
   assign start_d = start_ev | (start_q & ~start_clr);
   // The hold ends together with the flag
   assign start_hold_d = two_wire & start_d & (start_hold_q | (start_q & scl_fall));

   always_comb
   begin
      port_d = wr_port ? tws_port_type'(wdata_q[5:0]) : port_q;
      port_d.out_scl = port_d.out_scl ^ sw_toggle;
   end

   // Pin drive; open-drain lines only ever pull low
   wire scl_low_req = ~port_q.out_scl | start_hold_q | ovf_q;
   wire scl_oe_d    = port_q.dir_scl & (two_wire ? scl_low_req : 1'b1);
   wire scl_o_d     = two_wire ? 1'b0 : port_q.out_scl;
   wire sda_oe_d    = two_wire & port_q.dir_sda & (~latch_q | ~port_q.out_sda);
   // Latch open in the first clock half with an external clock, else always
   wire latch_open  = ~ext_clk | (scl_lvl == ctrl_q.clock_source_select[0]);

   wire [7:0] rd_mux = rs_ctrl   ? {ctrl_q, 2'h0} :
                       rs_status ? {start_q, ovf_q, stop_q, collision, cnt_q} :
                       rs_data   ? data_q :
                       rs_buffer ? buf_q :
                       rs_port   ? {2'h0, port_q} : 8'h00;

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         awaddr_q  <= '0;
         wdata_q   <= 8'h00;
         wstrb0_q  <= 1'b0;
      end
      else
      begin
         if (S_AXI_AWVALID && awready_q)
         begin
            awaddr_q  <= S_AXI_AWADDR;
            awready_q <= 1'b0;
         end
         if (S_AXI_WVALID && wready_q)
         begin
            wdata_q  <= S_AXI_WDATA[7:0];
            wstrb0_q <= S_AXI_WSTRB[0];
            wready_q <= 1'b0;
         end
         if (wr_fire)
         begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_hit ? RESP_OKAY : RESP_DECERR;
         end
         else if (bvalid_q && S_AXI_BREADY)
         begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rresp_q   <= RESP_OKAY;
         rdata_q   <= 8'h00;
      end
      else if (rd_fire)
      begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rresp_q   <= rd_hit ? RESP_OKAY : RESP_DECERR;
         rdata_q   <= rd_mux;
      end
      else if (rvalid_q && S_AXI_RREADY)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end

   // Shift unit core
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q       <= tws_ctrl_type'(RST_CTRL[7:2]);
         port_q       <= tws_port_type'(RST_PORT);
         data_q       <= RST_DATA;
         buf_q        <= RST_BUFFER;
         cnt_q        <= RST_COUNT;
         start_q      <= 1'b0;
         start_hold_q <= 1'b0;
         ovf_q        <= 1'b0;
         stop_q       <= 1'b0;
         latch_q      <= 1'b1;
      end
      else
      begin
         ctrl_q       <= wr_ctrl ? tws_ctrl_type'(wdata_q[7:2]) : ctrl_q;
         port_q       <= port_d;
         data_q       <= data_d;
         buf_q        <= ovf_ev ? data_d : buf_q;
         cnt_q        <= cnt_d;
         start_q      <= start_d;
         start_hold_q <= start_hold_d;
         ovf_q        <= ovf_ev | (ovf_q & ~ovf_clr);
         stop_q       <= stop_ev | (stop_q & ~stop_clr);
         latch_q      <= latch_open ? data_q[7] : latch_q;
      end
   end

   // Registered outputs
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sda_o_q     <= 1'b0;
         sda_oe_q    <= 1'b0;
         scl_o_q     <= 1'b0;
         scl_oe_q    <= 1'b0;
         do_o_q      <= 1'b1;
         do_oe_q     <= 1'b0;
         start_irq_q <= 1'b0;
         ovf_irq_q   <= 1'b0;
      end
      else
      begin
         sda_o_q     <= 1'b0;
         sda_oe_q    <= sda_oe_d;
         scl_o_q     <= scl_o_d;
         scl_oe_q    <= scl_oe_d;
         do_o_q      <= latch_q;
         do_oe_q     <= three_wire & port_q.dir_do;
         // Stop flag deliberately has no request line
         start_irq_q <= start_q & ctrl_q.start_irq_enable & port_q.glob_irq_enable;
         ovf_irq_q   <= ovf_q & ctrl_q.overflow_irq_enable & port_q.glob_irq_enable;
      end
   end

   assign S_AXI_AWREADY = awready_q;
   assign S_AXI_WREADY  = wready_q;
   assign S_AXI_BVALID  = bvalid_q;
   assign S_AXI_BRESP   = bresp_q;
   assign S_AXI_ARREADY = arready_q;
   assign S_AXI_RVALID  = rvalid_q;
   assign S_AXI_RRESP   = rresp_q;
   assign S_AXI_RDATA   = {24'h000000, rdata_q};
   assign SDA_O         = sda_o_q;
   assign SDA_OE        = sda_oe_q;
   assign SCL_O         = scl_o_q;
   assign SCL_OE        = scl_oe_q;
   assign DO_O          = do_o_q;
   assign DO_OE         = do_oe_q;
   assign START_IRQ     = start_irq_q;
   assign OVF_IRQ       = ovf_irq_q;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!rst_n);

   sequence s_start_seen;
      two_wire && start_q && !start_clr && scl_fall;
   endsequence
   sequence s_released;
      !start_q && !start_hold_q;
   endsequence

   property p_start_set;
      two_wire && start_det |=> start_q;
   endproperty
   a_start_set: assert property (p_start_set) else $error("start flag not set");

   property p_start_hold;
      s_start_seen |=> start_hold_q;
   endproperty
   a_start_hold: assert property (p_start_hold) else $error("start hold missing");

   property p_start_clear;
      start_clr && !start_ev |=> s_released;
   endproperty
   a_start_clear: assert property (p_start_clear) else $error("start clear failed");

   property p_ovf_wrap;
      ctrl_q.clock_source_select == CS_TIMER && TIMER_MATCH && !wr_status && cnt_q == CNT_MAX
         |=> ovf_q && cnt_q == 4'h0;
   endproperty
   a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow not flagged");

   property p_ovf_only_w1c;
      $fell(ovf_q) |-> $past(ovf_clr);
   endproperty
   a_ovf_only_w1c: assert property (p_ovf_only_w1c) else $error("overflow lost");

   property p_ovf_stretch;
      two_wire && ovf_q && port_q.dir_scl |=> SCL_OE && !SCL_O;
   endproperty
   a_ovf_stretch: assert property (p_ovf_stretch) else $error("SCL not stretched");

   property p_stop_set;
      two_wire && stop_det |=> stop_q;
   endproperty
   a_stop_set: assert property (p_stop_set) else $error("stop flag not set");

   property p_start_irq;
      start_q && ctrl_q.start_irq_enable && port_q.glob_irq_enable |=> START_IRQ;
   endproperty
   a_start_irq: assert property (p_start_irq) else $error("start irq missing");

   property p_write_wins;
      wr_data && shift_ev |=> data_q == $past(wdata_q);
   endproperty
   a_write_wins: assert property (p_write_wins) else $error("shift beat write");

   property p_buffer_copy;
      ovf_ev |=> buf_q == data_q;
   endproperty
   a_buffer_copy: assert property (p_buffer_copy) else $error("buffer not loaded");

   property p_shift_in;
      shift_ev && !wr_data |=> data_q == {$past(data_q[6:0]), $past(sda_lvl)};
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("bad shift");

   property p_both_edges;
      ext_clk && scl_edge && !sw_clk && !wr_status |=> cnt_q == $past(cnt_q) + 4'h1;
   endproperty
   a_both_edges: assert property (p_both_edges) else $error("edge not counted");

endmodule : tws_shift_unit

// file: hw/tws_pkg.sv
package tws_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL   = 8'h0d;
   localparam logic [7:0] IDX_STATUS = 8'h0e;
   localparam logic [7:0] IDX_DATA   = 8'h0f;
   localparam logic [7:0] IDX_BUFFER = 8'h10;
   localparam logic [7:0] IDX_PORT   = 8'h11;

   // Status bit positions
   localparam int unsigned ST_START = 7;
   localparam int unsigned ST_OVF   = 6;
   localparam int unsigned ST_STOP  = 5;
   localparam int unsigned ST_COLL  = 4;

   // Control strobe positions
   localparam int unsigned CT_SWCLK  = 1;
   localparam int unsigned CT_TOGGLE = 0;

   // Reset values
   localparam logic [7:0] RST_CTRL   = 8'h00;
   localparam logic [7:0] RST_DATA   = 8'h00;
   localparam logic [7:0] RST_BUFFER = 8'h00;
   localparam logic [5:0] RST_PORT   = 6'h00;
   localparam logic [3:0] RST_COUNT  = 4'h0;

   // Wire modes and clock sources
   localparam logic [1:0] WM_NONE  = 2'h0;
   localparam logic [1:0] WM_THREE = 2'h1;
   localparam logic [1:0] CS_SOFT  = 2'h0;
   localparam logic [1:0] CS_TIMER = 2'h1;
   localparam logic [1:0] CS_RISE  = 2'h2;
   localparam logic [1:0] CS_FALL  = 2'h3;

   localparam logic [3:0] CNT_MAX     = 4'hf;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef struct packed {
      logic       start_irq_enable;
      logic       overflow_irq_enable;
      logic [1:0] wire_mode_select;
      logic [1:0] clock_source_select;
   } tws_ctrl_type;

   typedef struct packed {
      logic glob_irq_enable;
      logic dir_do;
      logic dir_scl;
      logic dir_sda;
      logic out_scl;
      logic out_sda;
   } tws_port_type;
endpackage : tws_pkg

// file: verif/tws_bus_master.sv
`timescale 1ns/1ps
module tws_bus_master
   import tws_pkg::*;
#(
   // Half SCL period in CLK cycles; 4 keeps SCL well under CLK/2
   parameter int HALF = 4
)(
   // Clock and sensed lines
   input  wire logic clk,
   input  wire logic scl,
   input  wire logic sda,
   // Open-drain pulls, high pulls the line low
   output logic      scl_low,
   output logic      sda_low
);
   int stalls;

   initial
   begin
      scl_low = 1'h0;
      sda_low = 1'h0;
      stalls  = 0;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask : hold

   // The slave may stretch, so a released SCL is only trusted once it reads high
   task automatic rise();
      int i;
      scl_low <= 1'h0;
      i = 0;
      do
      begin
         @(negedge clk);
         i++;
      end
      while (scl !== 1'h1 && i < 400);
      if (scl !== 1'h1)
         stalls++;
      @(posedge clk);
   endtask : rise

   task automatic start();
      sda_low <= 1'h1;
      hold(HALF);
      scl_low <= 1'h1;
      hold(HALF);
   endtask : start

   // Low and high phases of HALF cycles each; SDA only moves in the middle of the low phase
   task automatic send_bit(input logic b, output logic s);
      sda_low <= ~b;
      hold(HALF / 2);
      rise();
      hold(HALF / 2 - 1);
      s = sda;
      hold(HALF - HALF / 2);
      scl_low <= 1'h1;
      hold(HALF / 2);
   endtask : send_bit

   task automatic stop();
      sda_low <= 1'h1;
      hold(HALF);
      rise();
      hold(HALF);
      sda_low <= 1'h0;
      hold(HALF);
   endtask : stop
endmodule : tws_bus_master

// file: verif/two_wire_shift_interface_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module two_wire_shift_interface_tb
   import tws_pkg::*;
();
   logic        clk, nrst;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        timer_match;
   logic        sda_o, sda_oe, scl_o, scl_oe, do_o, do_oe, start_irq, ovf_irq;
   logic        m_scl_low, m_sda_low;
   logic [7:0]  q;
   logic [1:0]  r;
   logic        s;
   int          errors, n_tests, k;
   // Open-drain lines with pull-ups
   wire logic   sda_line = ~((sda_oe & ~sda_o) | m_sda_low);
   wire logic   scl_line = ~((scl_oe & ~scl_o) | m_scl_low);

   tws_shift_unit #(
      .ADDR_W (8)
   ) dut (
      .CLK           (clk),
      .NRST          (nrst),
      .S_AXI_AWADDR  (awaddr),
      .S_AXI_AWVALID (awvalid),
      .S_AXI_AWREADY (awready),
      .S_AXI_WDATA   (wdata),
      .S_AXI_WSTRB   (4'hf),
      .S_AXI_WVALID  (wvalid),
      .S_AXI_WREADY  (wready),
      .S_AXI_BRESP   (bresp),
      .S_AXI_BVALID  (bvalid),
      .S_AXI_BREADY  (bready),
      .S_AXI_ARADDR  (araddr),
      .S_AXI_ARVALID (arvalid),
      .S_AXI_ARREADY (arready),
      .S_AXI_RDATA   (rdata),
      .S_AXI_RRESP   (rresp),
      .S_AXI_RVALID  (rvalid),
      .S_AXI_RREADY  (rready),
      .TIMER_MATCH   (timer_match),
      .SDA_I         (sda_line),
      .SDA_O         (sda_o),
      .SDA_OE        (sda_oe),
      .SCL_I         (scl_line),
      .SCL_O         (scl_o),
      .SCL_OE        (scl_oe),
      .DO_O          (do_o),
      .DO_OE         (do_oe),
      .START_IRQ     (start_irq),
      .OVF_IRQ       (ovf_irq)
   );

   tws_bus_master #(
      .HALF (4)
   ) m (
      .clk     (clk),
      .scl     (scl_line),
      .sda     (sda_line),
      .scl_low (m_scl_low),
      .sda_low (m_sda_low)
   );

   task automatic test_done();
      $display("comparisons %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // Ready is looked at on the falling edge, where it equals what the next rising edge samples
   task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      int i;
      bit aw, w, ar, b;
      b = 1'b0;
      @(posedge clk);
      awaddr  <= {idx[5:0], 2'h0};
      araddr  <= {idx[5:0], 2'h0};
      wdata   <= {24'h0, d};
      awvalid <= wr;
      wvalid  <= wr;
      bready  <= wr;
      arvalid <= ~wr;
      rready  <= ~wr;
      for (i = 0; i < 100 && !b; i++)
      begin
         @(negedge clk);
         aw = awvalid & awready;
         w  = wvalid & wready;
         ar = arvalid & arready;
         b  = (bready & bvalid) | (rready & rvalid);
         r  = wr ? bresp : rresp;
         q  = rdata[7:0];
         @(posedge clk);
         if (aw)
            awvalid <= 1'h0;
         if (w)
            wvalid <= 1'h0;
         if (ar)
            arvalid <= 1'h0;
         if (b)
         begin
            bready <= 1'h0;
            rready <= 1'h0;
         end
      end
      if (!b)
      begin
         errors++;
         test_done();
      end
   endtask : acc

   task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
      acc(1'h1, idx, d);
      `CHK(r, RESP_OKAY)
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] e);
      acc(1'h0, idx, 8'h00);
      `CHK(r, RESP_OKAY)
      `CHK(q & mask, e)
   endtask : rd_chk

   initial
   begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end

   initial
   begin
      nrst = 1'h0;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready, timer_match} = '0;
      errors = 0;
      n_tests = 0;
      cyc(2);
      nrst <= 1'h1;
      cyc(4);
      // Reset values; the buffer ignores writes; collision is live so left out
      wr_reg(IDX_BUFFER, 8'h55);
      for (k = 0; k < 5; k++)
         rd_chk(IDX_CTRL + 8'(k), (k == 1) ? 8'hef : 8'hff, 8'h00);
      acc(1'h0, 8'h00, 8'h00);
      `CHK(r, RESP_DECERR)
      `CHK(q, 8'h00)
      // Wire mode none: software strobe, then timer match
      wr_reg(IDX_DATA, 8'h81);
      wr_reg(IDX_CTRL, 8'h02);
      rd_chk(IDX_DATA, 8'hff, 8'h03);
      rd_chk(IDX_STATUS, 8'h0f, 8'h01);
      wr_reg(IDX_CTRL, 8'h04);
      timer_match <= 1'h1;
      cyc(1);
      timer_match <= 1'h0;
      rd_chk(IDX_DATA, 8'hff, 8'h07);
      rd_chk(IDX_STATUS, 8'h0f, 8'h02);
      // Timer held through a write: the write edge takes the value, the response edge shifts once
      timer_match <= 1'h1;
      wr_reg(IDX_DATA, 8'h81);
      timer_match <= 1'h0;
      rd_chk(IDX_DATA, 8'hff, 8'h03);
      // Three-wire with internal clock: latch always open
      wr_reg(IDX_PORT, 8'h3b);
      wr_reg(IDX_CTRL, 8'h10);
      wr_reg(IDX_DATA, 8'h80);
      cyc(2);
      `CHK({do_oe, do_o}, 2'h3)
      wr_reg(IDX_DATA, 8'h3f);
      cyc(2);
      `CHK(do_o, 1'h0)
      // Three-wire, falling pin edge: one full pulse gives two counts and the start flag
      wr_reg(IDX_CTRL, 8'h1c);
      wr_reg(IDX_STATUS, 8'h80);
      m.send_bit(1'h1, s);
      // The bit leaves SCL low; release it so the pulse completes and the bus idles high
      m.hold(2);
      m.rise();
      cyc(4);
      rd_chk(IDX_STATUS, 8'h8f, 8'h82);
      // Two-wire slave, address byte
      wr_reg(IDX_PORT, 8'h2b);
      wr_reg(IDX_CTRL, 8'he8);
      wr_reg(IDX_STATUS, 8'he0);
      m.start();
      rd_chk(IDX_STATUS, 8'hf0, 8'h80);
      `CHK({start_irq, scl_oe}, 2'h3)
      wr_reg(IDX_STATUS, 8'h80);
      cyc(4);
      `CHK({start_irq, scl_oe}, 2'h0)
      q = 8'ha5;
      for (k = 7; k >= 0; k--)
         m.send_bit(q[k], s);
      cyc(2);
      rd_chk(IDX_STATUS, 8'hff, 8'h40);
      `CHK({ovf_irq, scl_oe}, 2'h3)
      rd_chk(IDX_BUFFER, 8'hff, 8'ha5);
      // Acknowledge with SDA held low and count preloaded
      wr_reg(IDX_PORT, 8'h2e);
      wr_reg(IDX_STATUS, 8'h4e);
      cyc(4);
      `CHK(scl_oe, 1'h0)
      m.send_bit(1'h1, s);
      `CHK(s, 1'h0)
      cyc(2);
      rd_chk(IDX_STATUS, 8'hff, 8'h40);
      `CHK(scl_oe, 1'h1)
      rd_chk(IDX_BUFFER, 8'hff, 8'h4a);
      // Stop: flag only, no interrupt
      wr_reg(IDX_PORT, 8'h2b);
      wr_reg(IDX_STATUS, 8'h40);
      m.stop();
      rd_chk(IDX_STATUS, 8'hf0, 8'h20);
      `CHK({start_irq, ovf_irq}, 2'h0)
      wr_reg(IDX_STATUS, 8'h20);
      rd_chk(IDX_STATUS, 8'h20, 8'h00);
      // Bit 7 against the released line
      wr_reg(IDX_DATA, 8'h00);
      rd_chk(IDX_STATUS, 8'h10, 8'h10);
      wr_reg(IDX_DATA, 8'h80);
      rd_chk(IDX_STATUS, 8'h10, 8'h00);
      wr_reg(IDX_PORT, 8'h29);
      cyc(3);
      `CHK(scl_oe, 1'h1)
      `CHK(m.stalls, 0)
      test_done();
   end
endmodule : two_wire_shift_interface_tb
